/* File: inc/mcr_map.svh */
// register offsets, field positions, reset values and key of the motor command and telemetry block
// Behaviour
// - store bit 31 copies shadow into nonvolatile
// - load bit 30 reloads shadow from nonvolatile
// - write-only bits clear faults, clear retry count
// - store accepted only with key 0xA5
// - device clears tickle bit back to zero
// - state codes 00h-07h report startup states
// - codes 08h-0Eh running states, 0Ch reserved
// - codes 0Fh-18h parameter measurement, 13h reserved
// - tach speed unsigned 32-bit per-unit magnitude
// - hall speed unsigned 32-bit per-unit magnitude
// - supply current signed 32-bit Q27 value
// - three phase currents signed 32-bit Q27
// - decoder places variables at listed offsets
`ifndef MCR_MAP_SVH
`define MCR_MAP_SVH

`define MCR_ADDR_W          12
`define MCR_NVARS           37

`define MCR_OFS_CTRL_CMD    12'h0_0EA
`define MCR_OFS_MOTOR_STATE 12'h0_18C

// bit positions of the device control command register
`define MCR_BIT_NV_STORE    31
`define MCR_BIT_NV_LOAD     30
`define MCR_BIT_FLT_CLR     29
`define MCR_BIT_RETRY_CLR   28
`define MCR_KEY_HI          27
`define MCR_KEY_LO          20
`define MCR_BIT_TICKLE      10
`define MCR_NV_KEY          8'hA5
`define MCR_CTRL_RESET      32'h0000_0000
`define MCR_KEY_RESET       8'h00

// offsets of the read-only algorithm variables, in map order
`define MCR_OFS_TACH_SPD    12'h0_190
`define MCR_OFS_HALL_SPD    12'h0_192
`define MCR_OFS_DC_CUR      12'h0_42E
`define MCR_OFS_IA          12'h0_460
`define MCR_OFS_IB          12'h0_462
`define MCR_OFS_IC          12'h0_464
`define MCR_OFS_CSA_GAIN    12'h0_479
`define MCR_OFS_VOLT_SCALE  12'h0_47D
`define MCR_OFS_SUPPLY_V    12'h0_482
`define MCR_OFS_VA          12'h0_48A
`define MCR_OFS_VB          12'h0_48C
`define MCR_OFS_VC          12'h0_48E
`define MCR_OFS_SIN         12'h0_4D8
`define MCR_OFS_COS         12'h0_4DA
`define MCR_OFS_I_ALPHA     12'h0_504
`define MCR_OFS_I_BETA      12'h0_506
`define MCR_OFS_V_ALPHA     12'h0_508
`define MCR_OFS_V_BETA      12'h0_50A
`define MCR_OFS_I_D         12'h0_514
`define MCR_OFS_I_Q         12'h0_516
`define MCR_OFS_V_D         12'h0_518
`define MCR_OFS_V_Q         12'h0_51A
`define MCR_OFS_ALIGN_IQ    12'h0_54C
`define MCR_OFS_OL_SPD      12'h0_560
`define MCR_OFS_OL_IQ       12'h0_56E
`define MCR_OFS_CL_SPD      12'h0_5EE
`define MCR_OFS_POWER       12'h0_628
`define MCR_OFS_CL_ID       12'h0_630
`define MCR_OFS_CL_IQ       12'h0_632
`define MCR_OFS_SPIN_STATE  12'h0_6F0
`define MCR_OFS_SPIN_SPD    12'h0_6FA
`define MCR_OFS_POS_STATE   12'h0_724
`define MCR_OFS_POS_ANGLE   12'h0_746
`define MCR_OFS_BEMF_D      12'h0_772
`define MCR_OFS_BEMF_Q      12'h0_774
`define MCR_OFS_EST_SPD     12'h0_784
`define MCR_OFS_EST_ANGLE   12'h0_788

`define MCR_HALF_MASK       32'h0000_FFFF
`define MCR_FULL_MASK       32'hFFFF_FFFF

`endif

/* File: inc/mcr_pkg.sv */
// types of the motor command and telemetry block
`include "mcr_map.svh"

package mcr_pkg;

  typedef enum logic [7:0] {
    MCR_ST_IDLE             = 8'h00,
    MCR_ST_SPIN_DETECT      = 8'h01,
    MCR_ST_TRISTATE         = 8'h02,
    MCR_ST_BRAKE_ON_START   = 8'h03,
    MCR_ST_POSITION_DETECT  = 8'h04,
    MCR_ST_SLOW_FIRST_CYCLE = 8'h05,
    MCR_ST_ALIGN            = 8'h06,
    MCR_ST_OPEN_LOOP        = 8'h07,
    MCR_ST_CL_UNALIGNED     = 8'h08,
    MCR_ST_CL_ALIGNED       = 8'h09,
    MCR_ST_CL_ACTIVE_BRAKE  = 8'h0A,
    MCR_ST_SOFT_STOP        = 8'h0B,
    MCR_ST_BRAKE_ON_STOP    = 8'h0D,
    MCR_ST_FAULT            = 8'h0E,
    MCR_ST_PM_STOP_CHECK    = 8'h0F,
    MCR_ST_PM_STOP_WAIT     = 8'h10,
    MCR_ST_PM_BRAKE         = 8'h11,
    MCR_ST_PM_PARAM_INIT    = 8'h12,
    MCR_ST_PM_BEMF_MEASURE  = 8'h14,
    MCR_ST_PM_STALL_CURRENT = 8'h15,
    MCR_ST_PM_TORQUE_MODE   = 8'h16,
    MCR_ST_PARAM_MEAS_DONE  = 8'h17,
    MCR_ST_PM_FAULT         = 8'h18
  } mcr_motor_state_t;

  typedef struct packed {
    logic                     valid;
    logic                     write;
    logic [`MCR_ADDR_W-1:0]   addr;
    logic [31:0]              wdata;
  } mcr_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } mcr_rsp_t;

  typedef struct packed {
    logic nv_store_start;
    logic nv_load_start;
    logic fault_clear;
    logic retry_counter_clear;
    logic wdog_tickle;
  } mcr_cmd_t;

  typedef logic [`MCR_ADDR_W-1:0] mcr_addr_t;

  localparam mcr_addr_t MCR_VAR_OFS [`MCR_NVARS] = '{
    `MCR_OFS_TACH_SPD, `MCR_OFS_HALL_SPD, `MCR_OFS_DC_CUR, `MCR_OFS_IA, `MCR_OFS_IB, `MCR_OFS_IC,
    `MCR_OFS_CSA_GAIN, `MCR_OFS_VOLT_SCALE, `MCR_OFS_SUPPLY_V, `MCR_OFS_VA, `MCR_OFS_VB, `MCR_OFS_VC,
    `MCR_OFS_SIN, `MCR_OFS_COS, `MCR_OFS_I_ALPHA, `MCR_OFS_I_BETA, `MCR_OFS_V_ALPHA, `MCR_OFS_V_BETA,
    `MCR_OFS_I_D, `MCR_OFS_I_Q, `MCR_OFS_V_D, `MCR_OFS_V_Q, `MCR_OFS_ALIGN_IQ, `MCR_OFS_OL_SPD,
    `MCR_OFS_OL_IQ, `MCR_OFS_CL_SPD, `MCR_OFS_POWER, `MCR_OFS_CL_ID, `MCR_OFS_CL_IQ,
    `MCR_OFS_SPIN_STATE, `MCR_OFS_SPIN_SPD, `MCR_OFS_POS_STATE, `MCR_OFS_POS_ANGLE,
    `MCR_OFS_BEMF_D, `MCR_OFS_BEMF_Q, `MCR_OFS_EST_SPD, `MCR_OFS_EST_ANGLE
  };

  // gain and scale feedback are 16-bit fields, the rest full words
  localparam logic [31:0] MCR_VAR_MASK [`MCR_NVARS] = '{
    `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK,
    `MCR_HALF_MASK, `MCR_HALF_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK,
    `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK,
    `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK,
    `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK,
    `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK,
    `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK, `MCR_FULL_MASK
  };

endpackage

/* File: src/mcr_regs.sv */
// command register and read-only telemetry map of the motor controller
`include "mcr_map.svh"

module mcr_regs
  import mcr_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire mcr_req_t         req,
  output mcr_rsp_t              rsp,
  input  wire mcr_motor_state_t motor_state,
  input  wire logic [31:0]      var_words [`MCR_NVARS],
  input  wire logic             nv_store_done,
  input  wire logic             nv_load_done,
  output mcr_cmd_t              cmd
);

  logic       ctrl_wr;
  logic       key_ok;
  logic       store_busy_q;
  logic       load_busy_q;
  logic [7:0] key_q;
  logic       tickle_q;
  mcr_cmd_t   cmd_q;
  mcr_rsp_t   rsp_q;
  logic [31:0] var_hit_word [`MCR_NVARS];
  logic [31:0] var_rd;
  logic [31:0] ctrl_rd;
  logic [31:0] rd_d;

  assign ctrl_wr = req.valid && req.write && (req.addr == `MCR_OFS_CTRL_CMD);
  assign key_ok  = (req.wdata[`MCR_KEY_HI:`MCR_KEY_LO] == `MCR_NV_KEY);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      key_q <= `MCR_KEY_RESET;
    end else if (ctrl_wr) begin
      key_q <= req.wdata[`MCR_KEY_HI:`MCR_KEY_LO];
    end
  end

  // a new command in the done cycle wins, so a back-to-back request is never dropped
  // store busy
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      store_busy_q <= 1'b0;
    end else if (ctrl_wr && req.wdata[`MCR_BIT_NV_STORE] && key_ok) begin
      store_busy_q <= 1'b1;
    end else if (nv_store_done) begin
      store_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      load_busy_q <= 1'b0;
    end else if (ctrl_wr && req.wdata[`MCR_BIT_NV_LOAD]) begin
      load_busy_q <= 1'b1;
    end else if (nv_load_done) begin
      load_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tickle_q <= 1'b0;
    end else begin
      tickle_q <= ctrl_wr && req.wdata[`MCR_BIT_TICKLE];
    end
  end

  // one-cycle command pulses toward the nonvolatile, fault and watchdog logic
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= '0;
    end else begin
      cmd_q.nv_store_start      <= ctrl_wr && req.wdata[`MCR_BIT_NV_STORE] && key_ok;
      cmd_q.nv_load_start       <= ctrl_wr && req.wdata[`MCR_BIT_NV_LOAD];
      cmd_q.fault_clear         <= ctrl_wr && req.wdata[`MCR_BIT_FLT_CLR];
      cmd_q.retry_counter_clear <= ctrl_wr && req.wdata[`MCR_BIT_RETRY_CLR];
      cmd_q.wdog_tickle         <= ctrl_wr && req.wdata[`MCR_BIT_TICKLE];
    end
  end

  always_comb begin
    ctrl_rd                               = '0;
    ctrl_rd[`MCR_BIT_NV_STORE]            = store_busy_q;
    ctrl_rd[`MCR_BIT_NV_LOAD]             = load_busy_q;
    ctrl_rd[`MCR_KEY_HI:`MCR_KEY_LO]      = key_q;
    ctrl_rd[`MCR_BIT_TICKLE]              = tickle_q;
  end

  for (genvar i = 0; i < `MCR_NVARS; i++) begin : g_var
    assign var_hit_word[i] = (req.addr == MCR_VAR_OFS[i]) ? (var_words[i] & MCR_VAR_MASK[i]) : 32'h0000_0000;
  end

  always_comb begin
    var_rd = '0;
    for (int j = 0; j < `MCR_NVARS; j++) begin
      var_rd = var_rd | var_hit_word[j];
    end
  end

  always_comb begin
    if (req.addr == `MCR_OFS_CTRL_CMD) begin
      rd_d = ctrl_rd;
    end else if (req.addr == `MCR_OFS_MOTOR_STATE) begin
      rd_d = {24'h00_0000, motor_state};
    end else begin
      // unmapped offsets read zero
      rd_d = var_rd;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= req.valid;
      rsp_q.rdata <= (req.valid && !req.write) ? rd_d : 32'h0000_0000;
    end
  end

  assign rsp = rsp_q;
  assign cmd = cmd_q;

endmodule

/* File: test/mcr_nv_model.sv */
// nonvolatile memory stand-in answering store and load starts
module mcr_nv_model
  import mcr_pkg::*;
#(parameter int LAT = 8)
(
  input  wire logic     core_clk,
  input  wire logic     rst_b,
  input  wire mcr_cmd_t cmd,
  output logic          nv_store_done,
  output logic          nv_load_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] st_q;
  logic [7:0] ld_q;
  // slow on purpose so the busy bits can be seen by polling
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) st_q <= 8'h00;
    else if (cmd.nv_store_start) st_q <= 8'(LAT);
    else if (st_q != 8'h00) st_q <= st_q - 8'h01;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ld_q <= 8'h00;
    else if (cmd.nv_load_start) ld_q <= 8'(LAT);
    else if (ld_q != 8'h00) ld_q <= ld_q - 8'h01;
  end
  assign nv_store_done = (st_q == 8'h01);
  assign nv_load_done = (ld_q == 8'h01);
endmodule

/* File: test/mcr_regs_properties.sv */
// checker of the motor command and telemetry register port
`include "mcr_map.svh"

module mcr_regs_props
  import mcr_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst_b,
  input wire mcr_req_t         req,
  input wire mcr_rsp_t         rsp,
  input wire mcr_motor_state_t motor_state,
  input wire logic [31:0]      var_words [`MCR_NVARS],
  input wire logic             nv_store_done,
  input wire logic             nv_load_done,
  input wire mcr_cmd_t         cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic wr;
  logic rd;
  assign wr = req.valid && req.write && req.addr == `MCR_OFS_CTRL_CMD;
  assign rd = req.valid && !req.write;
  a_answer_late: assert property (req.valid |=> rsp.valid) else $error("missing answer");
  a_answer_cause: assert property (rsp.valid |-> $past(req.valid)) else $error("stray answer");
  a_store_keyed: assert property (wr && req.wdata[31] && req.wdata[27:20] == `MCR_NV_KEY |=> cmd.nv_store_start)
    else $error("store lost");
  a_store_locked: assert property (wr && req.wdata[27:20] != `MCR_NV_KEY |=> !cmd.nv_store_start)
    else $error("store without key");
  a_load_go: assert property (wr && req.wdata[30] |=> cmd.nv_load_start) else $error("load lost");
  a_clear_go: assert property (wr && req.wdata[29] |=> cmd.fault_clear && cmd.retry_counter_clear == $past(req.wdata[28]))
    else $error("clear lost");
  a_tickle_go: assert property (wr && req.wdata[10] |=> cmd.wdog_tickle) else $error("tickle lost");
  a_cmd_cause: assert property (cmd != '0 |-> $past(wr)) else $error("command without write");
  a_state_read: assert property (rd && req.addr == `MCR_OFS_MOTOR_STATE |=> rsp.rdata == {24'h00_0000, $past(motor_state)})
    else $error("state read wrong");
  a_ia_read: assert property (rd && req.addr == `MCR_OFS_IA |=> rsp.rdata == $past(var_words[3]))
    else $error("phase read wrong");
  c_store: cover property (cmd.nv_store_start);
  c_load: cover property (cmd.nv_load_start);
  c_tickle: cover property (cmd.wdog_tickle);
endmodule

bind mcr_regs mcr_regs_props u_props (.core_clk(core_clk), .rst_b(rst_b), .req(req), .rsp(rsp),
  .motor_state(motor_state), .var_words(var_words), .nv_store_done(nv_store_done),
  .nv_load_done(nv_load_done), .cmd(cmd));

/* File: test/tb_motor_ctrl_command_and_telemetry.sv */
// testbench of the motor command and telemetry registers
`include "mcr_map.svh"

module tb_motor_ctrl_command_and_telemetry;
  import mcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic             core_clk;
  logic             rst_b;
  mcr_req_t         req;
  mcr_rsp_t         rsp;
  mcr_motor_state_t motor_state;
  logic [31:0]      var_words [`MCR_NVARS];
  logic             nv_store_done;
  logic             nv_load_done;
  mcr_cmd_t         cmd;
  mcr_cmd_t         cv;
  logic [31:0]      rd;
  int               miscompares;
  int               check_count;

  mcr_regs uut (.core_clk(core_clk), .rst_b(rst_b), .req(req), .rsp(rsp), .motor_state(motor_state),
    .var_words(var_words), .nv_store_done(nv_store_done), .nv_load_done(nv_load_done), .cmd(cmd));
  mcr_nv_model u_nv (.core_clk(core_clk), .rst_b(rst_b), .cmd(cmd), .nv_store_done(nv_store_done),
    .nv_load_done(nv_load_done));

  task final_report;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one access: strobe for one edge, answer looked at in the following cycle
  task acc(input logic w, input mcr_addr_t a, input logic [31:0] d);
    @(posedge core_clk) req <= '{1'b1, w, a, d};
    @(posedge core_clk) req <= '0;
    #1;
    rd = rsp.rdata;
    cv = cmd;
    chk(32'(rsp.valid), 32'h0000_0001);
  endtask

  task poll(input int b);
    int i;
    for (i = 0; i < 20; i++) begin
      acc(1'b0, `MCR_OFS_CTRL_CMD, '0);
      if (rd[b] === 1'b0) break;
    end
    if (i == 20) begin
      miscompares++;
      final_report;
    end
  endtask

  task t_map;
    for (int i = 0; i < `MCR_NVARS; i++) begin
      acc(1'b0, MCR_VAR_OFS[i], '0);
      chk(rd, var_words[i] & MCR_VAR_MASK[i]);
    end
    acc(1'b1, `MCR_OFS_IA, 32'hFFFF_FFFF);
    acc(1'b0, `MCR_OFS_IA, '0);
    chk(rd, var_words[3]);
    // reserved offsets are only ever read
    acc(1'b0, 12'h0_000, '0);
    chk(rd, 32'h0000_0000);
  endtask

  task t_states;
    for (int c = 0; c <= 8'h18; c++) begin
      if (c != 8'h0C && c != 8'h13) begin
        @(posedge core_clk) motor_state <= mcr_motor_state_t'(c[7:0]);
        acc(1'b0, `MCR_OFS_MOTOR_STATE, '0);
        chk(rd, 32'(c));
      end
    end
  endtask

  task t_nv;
    acc(1'b1, `MCR_OFS_CTRL_CMD, 32'h8330_0000);
    chk(32'(cv.nv_store_start), 32'h0000_0000);
    acc(1'b1, `MCR_OFS_CTRL_CMD, 32'h8A50_0000);
    chk(32'(cv.nv_store_start), 32'h0000_0001);
    acc(1'b0, `MCR_OFS_CTRL_CMD, '0);
    chk(rd, 32'h8A50_0000);
    poll(31);
    acc(1'b1, `MCR_OFS_CTRL_CMD, 32'h4000_0000);
    chk(32'(cv), 32'h0000_0008);
    poll(30);
  endtask

  task t_clear_tickle;
    acc(1'b1, `MCR_OFS_CTRL_CMD, 32'h3000_0400);
    chk(32'(cv), 32'h0000_0007);
    acc(1'b0, `MCR_OFS_CTRL_CMD, '0);
    chk(rd, 32'h0000_0000);
  endtask

  // mid-run reset drops a running store, its busy bit and the stored key
  task t_reset;
    acc(1'b1, `MCR_OFS_CTRL_CMD, 32'h8A50_0000);
    @(posedge core_clk) rst_b <= 1'b0;
    @(posedge core_clk) rst_b <= 1'b1;
    #1;
    chk(32'(cmd), 32'h0000_0000);
    acc(1'b0, `MCR_OFS_CTRL_CMD, '0);
    chk(rd, 32'h0000_0000);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    rst_b = 1'b0;
    req = '0;
    motor_state = MCR_ST_IDLE;
    miscompares = 0;
    check_count = 0;
    // top bit set so signed words read back negative
    for (int i = 0; i < `MCR_NVARS; i++) var_words[i] = 32'hF0A5_0000 + 32'(i);
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    acc(1'b0, `MCR_OFS_CTRL_CMD, '0);
    chk(rd, 32'h0000_0000);
    t_map;
    t_states;
    t_nv;
    t_clear_tickle;
    t_reset;
    final_report;
  end
endmodule
